// ===== shared/serial_port_map.vh
// register indices, field positions, reset values and timing counts of the serial port block
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// register indices; byte address on the bus is four times the index
`define IDX_RECEIVE_DATA 10'h119
`define IDX_TRANSMIT_DATA 10'h11A
`define IDX_BAUD_DIVISOR_LOW 10'h11B
`define IDX_BAUD_DIVISOR_HIGH 10'h11C
`define IDX_RECEIVE_STATUS_CONTROL 10'h11D
`define IDX_TRANSMIT_STATUS_CONTROL 10'h11E
`define IDX_BAUD_CONTROL 10'h11F
`define IDX_EVENT_STATUS 10'h120
`define IDX_EVENT_MASK 10'h121

// baud control fields
`define BIT_AUTOBAUD_OVERFLOW_FLAG 7
`define BIT_RECEIVER_IDLE_FLAG 6
`define BIT_LINE_POLARITY_SELECT 4
`define BIT_WIDE_DIVISOR_SELECT 3
`define BIT_WAKEUP_EDGE_ENABLE 1
`define BIT_AUTOBAUD_ENABLE 0

// transmit status control fields
`define BIT_MODE_SELECT 4
`define BIT_HIGH_SPEED_SELECT 2
`define BIT_SHIFT_EMPTY 1

// event status and mask fields
`define BIT_EVT_RECEIVE 0
`define BIT_EVT_AUTOBAUD_DONE 1
`define BIT_EVT_AUTOBAUD_OVERFLOW 2
`define EVENT_WIDTH 3

// reset values
`define RST_BYTE 8'h00
`define RST_DIVISOR 16'h0000
`define RST_EVENTS 3'h0

// auto-baud: falling edges in the calibration character 0x55 (start edge included)
`define AUTOBAUD_EDGES 3'h5
// log2 of the bit periods spanned by the measurement
`define AUTOBAUD_SPAN_SHIFT 3

`endif

// ===== rtl/baud_tick_gen.v
// baud clock generator: one tick every divisor plus one system clocks
`timescale 1ns/1ps
module baud_tick_gen (
   input wire clk,
   input wire reset_n,
   // divisor setup
   input wire [15:0] divisor_value,
   input wire wide_divisor_select,
   input wire restart,
   // tick out
   output reg tick
);
   reg [15:0] count;
   wire [15:0] reload;

   // narrow divisor uses the low byte only
   assign reload = wide_divisor_select ? divisor_value : {8'h00, divisor_value[7:0]};

   always @(posedge clk) begin
      if (!reset_n) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (restart) begin
         count <= reload;
         tick <= 1'b0;
      end else if (count == 16'h0000) begin
         count <= reload;
         tick <= 1'b1;
      end else begin
         count <= count - 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule // baud_tick_gen

// ===== rtl/serial_port_regs.v
// baud control, data and divisor registers of the serial port, with wishbone slave
`timescale 1ns/1ps
`include "serial_port_map.vh"

// Contract
// - in asynchronous mode bit 7 of baud control is set when the auto-baud timer overflows.
// - in asynchronous mode bit 6 reads 1 while the receiver is idle and 0 while receiving; the code also reads 0 while auto-baud is enabled.
// - in asynchronous mode polarity bit 4 set makes transmit idle low with inverted data.
// - in synchronous mode polarity bit 4 set moves data on the rising clock edge, else falling.
// - bit 3 set uses the full 16-bit divisor, clear uses only the 8-bit low byte.
// - with wake-up bit 1 set in asynchronous mode a falling receive edge sets the receive flag.
// - the wake-up bit clears itself once the wake-up edge has set the receive flag.
// - auto-baud bit 0 starts detection in asynchronous mode and clears itself when done.
// - the received byte reads from a read-only byte register at index 0x119, reset zero.
// - the byte to send is written to a read/write byte register at index 0x11A, reset zero.
// - the 16-bit divisor at index 0x11B is reached as separate low and high byte registers.
// - baud control sits at index 0x11F, bits 5 and 2 are absent and all bits except idle bit 6 reset to 0.
// - mode select set means synchronous; baud control fields except polarity and bit 3 act only async.
// - async high speed gives bit rate of baud clock over 4 with wide divisor, else over 16.
module serial_port_regs (
   // clock and reset
   input wire SYS_CLK,
   input wire RESET_N,
   // wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [11:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // receive engine
   input wire RX_PIN,
   input wire RX_ACTIVE,
   input wire RX_BYTE_VALID,
   input wire [7:0] RX_BYTE,
   // transmit engine
   input wire TX_RAW,
   input wire TX_SHIFT_EMPTY,
   output reg [7:0] TX_BYTE,
   output reg TX_LOAD,
   output wire TX_PIN,
   // clocking to the engines
   output wire BAUD_TICK,
   output reg BIT_TICK,
   output wire SYNC_MODE,
   output wire SYNC_RISING_EDGE,
   output wire [7:0] RX_CONTROL,
   // interrupt
   output wire IRQ
);
   localparam AB_IDLE = 2'b00;
   localparam AB_WAIT_START = 2'b01;
   localparam AB_MEASURE = 2'b10;

   reg [7:0] receive_data;
   reg [15:0] baud_divisor;
   reg [7:0] receive_status_control;
   reg [7:0] transmit_status_control;
   reg autobaud_overflow_flag;
   reg line_polarity_select;
   reg wide_divisor_select;
   reg wakeup_edge_enable;
   reg autobaud_enable;
   reg [`EVENT_WIDTH-1:0] event_status;
   reg [`EVENT_WIDTH-1:0] event_mask;
   reg [1:0] ab_state;
   reg [1:0] next_ab_state;
   reg [2:0] ab_edges;
   reg [15:0] ab_count;
   reg rx_prev;
   reg [5:0] bit_count;
   reg [31:0] next_dat;

   wire access;
   wire wr;
   wire [9:0] idx;
   wire mode_sync;
   wire high_speed;
   wire rx_fall;
   wire wake_event;
   wire ab_done;
   wire ab_overflow;
   wire divisor_write;
   wire [7:0] baud_control_read;
   wire [`EVENT_WIDTH-1:0] event_set;
   wire [15:0] ab_result;

   // log2 of baud clock ticks per bit for the chosen speed and divisor width
   function [2:0] rate_shift;
      input sync_mode;
      input hs;
      input wide;
      begin
         if (sync_mode)
            rate_shift = 3'h2;
         else if (hs && wide)
            rate_shift = 3'h2;
         else if (hs || wide)
            rate_shift = 3'h4;
         else
            rate_shift = 3'h6;
      end
   endfunction

   // is this index the one being accessed
   function hit;
      input [9:0] a;
      input [9:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   assign access = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr = access && WB_WE_I && WB_SEL_I[0];
   assign idx = WB_ADR_I[11:2];
   assign mode_sync = transmit_status_control[`BIT_MODE_SELECT];
   assign high_speed = transmit_status_control[`BIT_HIGH_SPEED_SELECT];
   assign rx_fall = rx_prev && !RX_PIN;
   assign wake_event = wakeup_edge_enable && !mode_sync && rx_fall;
   assign divisor_write = wr && (hit(idx, `IDX_BAUD_DIVISOR_LOW) ||
                                 hit(idx, `IDX_BAUD_DIVISOR_HIGH));

   // baud control read image, absent bits read zero
   assign baud_control_read = {autobaud_overflow_flag,
                               !mode_sync && !RX_ACTIVE && ab_state == AB_IDLE,
                               1'b0,
                               line_polarity_select,
                               wide_divisor_select,
                               1'b0,
                               wakeup_edge_enable,
                               autobaud_enable};

   // polarity inverts the idle level and data only in asynchronous mode
   assign TX_PIN = mode_sync ? TX_RAW : TX_RAW ^ line_polarity_select;
   assign SYNC_MODE = mode_sync;
   assign SYNC_RISING_EDGE = mode_sync && line_polarity_select;
   assign RX_CONTROL = receive_status_control;

   baud_tick_gen u_baud (
      .clk(SYS_CLK),
      .reset_n(RESET_N),
      .divisor_value(baud_divisor),
      .wide_divisor_select(wide_divisor_select),
      .restart(divisor_write),
      .tick(BAUD_TICK)
   );

   // bit clock: baud ticks divided by 4, 16 or 64
   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         bit_count <= 6'h00;
         BIT_TICK <= 1'b0;
      end else if (divisor_write) begin
         bit_count <= 6'h00;
         BIT_TICK <= 1'b0;
      end else if (BAUD_TICK) begin
         if (bit_count == ((6'h01 << rate_shift(mode_sync, high_speed, wide_divisor_select))
                           - 6'h01)) begin
            bit_count <= 6'h00;
            BIT_TICK <= 1'b1;
         end else begin
            bit_count <= bit_count + 6'h01;
            BIT_TICK <= 1'b0;
         end
      end else begin
         BIT_TICK <= 1'b0;
      end
   end

   // auto-baud: count system clocks from the start edge to the fifth falling edge
   always @* begin
      next_ab_state = ab_state;
      case (ab_state)
         AB_IDLE: begin
            if (autobaud_enable && !mode_sync)
               next_ab_state = AB_WAIT_START;
         end
         AB_WAIT_START: begin
            if (!autobaud_enable || mode_sync)
               next_ab_state = AB_IDLE;
            else if (rx_fall)
               next_ab_state = AB_MEASURE;
         end
         AB_MEASURE: begin
            if (!autobaud_enable || mode_sync || ab_done || ab_overflow)
               next_ab_state = AB_IDLE;
         end
         default: begin
            next_ab_state = AB_IDLE;
         end
      endcase
   end

   assign ab_done = (ab_state == AB_MEASURE) && rx_fall && (ab_edges == `AUTOBAUD_EDGES - 3'h1);
   assign ab_overflow = (ab_state == AB_MEASURE) && (ab_count == 16'hFFFF) && !ab_done;
   // measured span covers eight bits of baud-clock groups; divisor is one less
   assign ab_result = (ab_count >> (rate_shift(mode_sync, high_speed, wide_divisor_select)
                       + `AUTOBAUD_SPAN_SHIFT)) - 16'h0001;

   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ab_state <= AB_IDLE;
         ab_edges <= 3'h0;
         ab_count <= 16'h0000;
         rx_prev <= 1'b1;
      end else begin
         ab_state <= next_ab_state;
         rx_prev <= RX_PIN;
         if (ab_state != AB_MEASURE) begin
            ab_edges <= 3'h1;
            ab_count <= 16'h0000;
         end else begin
            if (ab_count != 16'hFFFF)
               ab_count <= ab_count + 16'h0001;
            if (rx_fall)
               ab_edges <= ab_edges + 3'h1;
         end
      end
   end

   // event flags: hardware set wins over a write-one clear in the same cycle
   assign event_set = {ab_overflow, ab_done, RX_BYTE_VALID | wake_event};

   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         event_status <= `RST_EVENTS;
         event_mask <= `RST_EVENTS;
      end else begin
         if (wr && hit(idx, `IDX_EVENT_STATUS))
            event_status <= (event_status & ~WB_DAT_I[`EVENT_WIDTH-1:0]) | event_set;
         else
            event_status <= event_status | event_set;
         if (wr && hit(idx, `IDX_EVENT_MASK))
            event_mask <= WB_DAT_I[`EVENT_WIDTH-1:0];
      end
   end

   assign IRQ = |(event_status & event_mask);

   // baud control register
   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         autobaud_overflow_flag <= 1'b0;
         line_polarity_select <= 1'b0;
         wide_divisor_select <= 1'b0;
         wakeup_edge_enable <= 1'b0;
         autobaud_enable <= 1'b0;
      end else begin
         if (wr && hit(idx, `IDX_BAUD_CONTROL)) begin
            line_polarity_select <= WB_DAT_I[`BIT_LINE_POLARITY_SELECT];
            wide_divisor_select <= WB_DAT_I[`BIT_WIDE_DIVISOR_SELECT];
            wakeup_edge_enable <= WB_DAT_I[`BIT_WAKEUP_EDGE_ENABLE];
            autobaud_enable <= WB_DAT_I[`BIT_AUTOBAUD_ENABLE];
         end else begin
            if (wake_event)
               wakeup_edge_enable <= 1'b0;
            if (ab_done || ab_overflow)
               autobaud_enable <= 1'b0;
         end
         // overflow is cleared when auto-baud leaves idle for wait-start, before any start edge
         if (ab_overflow)
            autobaud_overflow_flag <= 1'b1;
         else if (ab_state == AB_IDLE && next_ab_state == AB_WAIT_START)
            autobaud_overflow_flag <= 1'b0;
      end
   end

   // data, divisor and status control registers
   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         receive_data <= `RST_BYTE;
         TX_BYTE <= `RST_BYTE;
         TX_LOAD <= 1'b0;
         baud_divisor <= `RST_DIVISOR;
         receive_status_control <= `RST_BYTE;
         transmit_status_control <= `RST_BYTE;
      end else begin
         TX_LOAD <= 1'b0;
         if (RX_BYTE_VALID)
            receive_data <= RX_BYTE;
         if (wr && hit(idx, `IDX_TRANSMIT_DATA)) begin
            TX_BYTE <= WB_DAT_I[7:0];
            TX_LOAD <= 1'b1;
         end
         if (ab_done)
            baud_divisor <= ab_result;
         else if (wr && hit(idx, `IDX_BAUD_DIVISOR_LOW))
            baud_divisor[7:0] <= WB_DAT_I[7:0];
         else if (wr && hit(idx, `IDX_BAUD_DIVISOR_HIGH))
            baud_divisor[15:8] <= WB_DAT_I[7:0];
         if (wr && hit(idx, `IDX_RECEIVE_STATUS_CONTROL))
            receive_status_control <= WB_DAT_I[7:0];
         if (wr && hit(idx, `IDX_TRANSMIT_STATUS_CONTROL))
            transmit_status_control <= WB_DAT_I[7:0];
      end
   end

   // read decode; unmapped indices read zero
   always @* begin
      next_dat = 32'h00000000;
      if (hit(idx, `IDX_RECEIVE_DATA)) begin
         next_dat[7:0] = receive_data;
      end else if (hit(idx, `IDX_TRANSMIT_DATA)) begin
         next_dat[7:0] = TX_BYTE;
      end else if (hit(idx, `IDX_BAUD_DIVISOR_LOW)) begin
         next_dat[7:0] = baud_divisor[7:0];
      end else if (hit(idx, `IDX_BAUD_DIVISOR_HIGH)) begin
         next_dat[7:0] = baud_divisor[15:8];
      end else if (hit(idx, `IDX_RECEIVE_STATUS_CONTROL)) begin
         next_dat[7:0] = receive_status_control;
      end else if (hit(idx, `IDX_TRANSMIT_STATUS_CONTROL)) begin
         next_dat[7:0] = transmit_status_control;
         next_dat[`BIT_SHIFT_EMPTY] = TX_SHIFT_EMPTY;
      end else if (hit(idx, `IDX_BAUD_CONTROL)) begin
         next_dat[7:0] = baud_control_read;
      end else if (hit(idx, `IDX_EVENT_STATUS)) begin
         next_dat[`EVENT_WIDTH-1:0] = event_status;
      end else if (hit(idx, `IDX_EVENT_MASK)) begin
         next_dat[`EVENT_WIDTH-1:0] = event_mask;
      end
   end

   // one-cycle acknowledge, dropped the cycle after
   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= access;
         if (access && !WB_WE_I)
            WB_DAT_O <= next_dat;
      end
   end
endmodule // serial_port_regs

// ===== verification/remote_serial_model.sv
// remote serial transmitter model: line edges and received bytes
`timescale 1ns/1ps
module remote_serial_model (
   // clock
   input wire clk,
   // receive side
   output logic rx_pin = 1'b1,
   output logic rx_active = 1'b0,
   output logic rx_byte_valid = 1'b0,
   output logic [7:0] rx_byte = 8'h00
);
   // n falling edges gap cycles apart, line high in between
   task automatic falls(input int n, input int gap);
      repeat (n) begin
         @(posedge clk);
         rx_pin <= 1'b0;
         repeat (gap / 2) @(posedge clk);
         rx_pin <= 1'b1;
         repeat (gap - gap / 2 - 1) @(posedge clk);
      end
   endtask
   // byte is only meaningful while valid is high
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      rx_active <= 1'b1;
      repeat (4) @(posedge clk);
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      @(posedge clk);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~b;
      rx_active <= 1'b0;
   endtask
endmodule // remote_serial_model

// ===== verification/serial_port_assertions.sv
// assertions on bus answers, transmit load, line polarity and tick spacing
`timescale 1ns/1ps
module serial_port_checker (
   // clock and reset
   input wire SYS_CLK,
   input wire RESET_N,
   // bus
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [11:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   // engines and line
   input wire TX_RAW,
   input wire [7:0] TX_BYTE,
   input wire TX_LOAD,
   input wire TX_PIN,
   input wire BAUD_TICK,
   input wire SYNC_MODE,
   input wire SYNC_RISING_EDGE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire [9:0] idx = WB_ADR_I[11:2];
   wire wr0 = take && WB_WE_I && WB_SEL_I[0];
   wire rd0 = take && !WB_WE_I;
   wire cfg = wr0 && idx >= 10'h11B && idx <= 10'h11F;
   logic [15:0] div;
   logic wide, armed, seen;
   logic [16:0] cnt;
   wire [16:0] want = (wide ? {1'b0, div} : {9'h000, div[7:0]}) + 17'h00001;
   // spacing is judged only once software set the divisor, never after auto-baud
   always @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         armed <= 1'b0;
         seen <= 1'b0;
      end else begin
         seen <= !cfg && (seen || BAUD_TICK);
         armed <= (armed || (cfg && idx < 10'h11D)) && !(cfg && idx == 10'h11F && WB_DAT_I[0]);
      end
      cnt <= BAUD_TICK ? 17'h00001 : cnt + 17'h00001;
      if (cfg && idx == 10'h11B) div[7:0] <= WB_DAT_I[7:0];
      if (cfg && idx == 10'h11C) div[15:8] <= WB_DAT_I[7:0];
      if (cfg && idx == 10'h11F) wide <= WB_DAT_I[3];
   end
   ack_answer_a: assert property (take |=> WB_ACK_O)
      else $error("request not answered");
   baud_gap_a: assert property (BAUD_TICK && seen && armed |-> cnt == want)
      else $error("baud tick spacing wrong");
   tx_load_a: assert property (wr0 && idx == 10'h11A |=> TX_LOAD &&
      TX_BYTE == $past(WB_DAT_I[7:0])) else $error("transmit byte not loaded");
   load_cause_a: assert property (TX_LOAD |-> $past(wr0 && idx == 10'h11A))
      else $error("spurious transmit load");
   unmapped_read_a: assert property (rd0 && (idx < 10'h119 || idx > 10'h121) |=>
      WB_DAT_O == 32'h00000000) else $error("unmapped read nonzero");
   absent_bits_a: assert property (rd0 && idx == 10'h11F |=>
      WB_DAT_O[31:8] == 24'h000000 && !WB_DAT_O[5] && !WB_DAT_O[2]) else $error("absent bits set");
   sync_line_a: assert property (SYNC_MODE |-> TX_PIN == TX_RAW)
      else $error("line inverted in sync mode");
   sync_edge_a: assert property (SYNC_RISING_EDGE |-> SYNC_MODE)
      else $error("edge select outside sync mode");
   c_load: cover property (TX_LOAD);
   c_gap: cover property (BAUD_TICK && seen && armed);
   c_sync: cover property (SYNC_RISING_EDGE);
endmodule // serial_port_checker
bind serial_port_regs serial_port_checker chk_u (.SYS_CLK, .RESET_N, .WB_CYC_I, .WB_STB_I,
   .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .TX_RAW, .TX_BYTE,
   .TX_LOAD, .TX_PIN, .BAUD_TICK, .SYNC_MODE, .SYNC_RISING_EDGE);

// ===== verification/testbench.sv
// self-checking bench for the serial port register block
`timescale 1ns/1ps
module testbench;
   logic SYS_CLK = 1'b0, RESET_N = 1'b0, req = 1'b0, wen = 1'b0, tx_raw = 1'b1;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h00000000, q;
   int error_cnt = 0, checked = 0;
   wire [31:0] dat_o;
   wire [7:0] rx_byte, tx_byte;
   wire ack, rx_pin, rx_act, rx_vld, tx_pin, tick, btick, srise, irq;
   always #10 SYS_CLK = ~SYS_CLK;
   remote_serial_model far_u (.clk(SYS_CLK), .rx_pin(rx_pin), .rx_active(rx_act),
      .rx_byte_valid(rx_vld), .rx_byte(rx_byte));
   serial_port_regs dut_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .WB_CYC_I(req),
      .WB_STB_I(req), .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .RX_PIN(rx_pin), .RX_ACTIVE(rx_act),
      .RX_BYTE_VALID(rx_vld), .RX_BYTE(rx_byte), .TX_RAW(tx_raw), .TX_SHIFT_EMPTY(1'b1),
      .TX_BYTE(tx_byte), .TX_LOAD(), .TX_PIN(tx_pin), .BAUD_TICK(tick), .BIT_TICK(btick),
      .SYNC_MODE(), .SYNC_RISING_EDGE(srise), .RX_CONTROL(), .IRQ(irq));
   task automatic final_report;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one classic cycle, released at the edge that samples ack
   task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
      int n;
      @(posedge SYS_CLK);
      req <= 1'b1;
      wen <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h000000, d};
      @(posedge SYS_CLK);
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge SYS_CLK);
      q = dat_o;
      req <= 1'b0;
      chk(ack, 1'b1);
      if (ack !== 1'b1) final_report();
   endtask
   task automatic rd(input logic [9:0] i, input logic [7:0] e);
      wb(1'b0, i, 8'h00);
      chk(q, {24'h000000, e});
   endtask
   // clock cycles from one baud tick, or bit tick when b is set, to the next
   task automatic gap(input logic b, input int e);
      int g;
      for (g = 0; g < 600 && (b ? btick : tick) !== 1'b1; g++) @(posedge SYS_CLK);
      @(posedge SYS_CLK);
      for (g = 1; g < 600 && (b ? btick : tick) !== 1'b1; g++) @(posedge SYS_CLK);
      chk(g, e);
      if (g >= 600) final_report();
   endtask
   initial begin
      repeat (8) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd(10'h119 + 10'(i), 8'h00);
      rd(10'h11F, 8'h40);
      wb(1'b1, 10'h11F, 8'hFE);
      rd(10'h11F, 8'h5A);
      wb(1'b1, 10'h11A, 8'hA5);
      chk(tx_byte, 8'hA5);
      rd(10'h11A, 8'hA5);
      wb(1'b1, 10'h119, 8'h3C);
      rd(10'h119, 8'h00);
      rd(10'h122, 8'h00);
      wb(1'b1, 10'h11C, 8'h01);
      wb(1'b1, 10'h11B, 8'h03);
      rd(10'h11C, 8'h01);
      gap(1'b0, 260);
      wb(1'b1, 10'h11F, 8'h00);
      gap(1'b0, 4);
      rd(10'h11B, 8'h03);
      $display("register and divisor tests done");
      wb(1'b1, 10'h121, 8'h01);
      far_u.send(8'hC3);
      @(posedge SYS_CLK);
      chk(irq, 1'b1);
      rd(10'h119, 8'hC3);
      wb(1'b1, 10'h120, 8'h01);
      chk(irq, 1'b0);
      wb(1'b1, 10'h121, 8'h00);
      fork
         far_u.send(8'h5A);
         begin
            repeat (2) @(posedge SYS_CLK);
            rd(10'h11F, 8'h00);
         end
      join
      rd(10'h120, 8'h01);
      chk(irq, 1'b0);
      wb(1'b1, 10'h120, 8'h01);
      rd(10'h11F, 8'h40);
      $display("receive and interrupt tests done");
      wb(1'b1, 10'h11F, 8'h02);
      far_u.falls(1, 8);
      rd(10'h11F, 8'h40);
      rd(10'h120, 8'h01);
      wb(1'b1, 10'h120, 8'h01);
      wb(1'b1, 10'h11F, 8'h01);
      far_u.falls(5, 264);
      rd(10'h11F, 8'h40);
      rd(10'h11B, 8'h01);
      rd(10'h11C, 8'h00);
      rd(10'h120, 8'h02);
      wb(1'b1, 10'h120, 8'h07);
      wb(1'b1, 10'h11F, 8'h01);
      far_u.falls(1, 8);
      repeat (65540) @(posedge SYS_CLK);
      rd(10'h11F, 8'hC0);
      rd(10'h120, 8'h04);
      wb(1'b1, 10'h11F, 8'h01);
      rd(10'h11F, 8'h01);
      $display("wake and auto-baud tests done");
      wb(1'b1, 10'h11E, 8'h04);
      wb(1'b1, 10'h11F, 8'h08);
      gap(1'b1, 8);
      wb(1'b1, 10'h11F, 8'h00);
      gap(1'b1, 32);
      $display("bit clock tests done");
      wb(1'b1, 10'h11F, 8'h10);
      tx_raw <= 1'b0;
      @(posedge SYS_CLK);
      chk(tx_pin, 1'b1);
      wb(1'b1, 10'h11E, 8'h10);
      chk(srise, 1'b1);
      chk(tx_pin, 1'b0);
      $display("polarity tests done");
      repeat (4) @(posedge SYS_CLK);
      final_report();
   end
endmodule // testbench
